// ==== verilog/phsr_pkg.sv ====
// Constants and types for the holdover control and synthesizer status registers
package phsr_pkg;

    localparam int          PHSR_DATA_W        = 32;
    localparam int          PHSR_ADDR_W        = 12;
    localparam int          PHSR_REG_W         = 8;
    localparam int          PHSR_SYNC_STAGES   = 2;

    // Register indices; byte address is four times the index
    localparam logic [9:0]  PHSR_IDX_HOLD_CTRL = 10'h01D;
    localparam logic [9:0]  PHSR_IDX_STATUS    = 10'h01F;
    localparam logic [11:0] PHSR_ADDR_HOLD_CTRL = {PHSR_IDX_HOLD_CTRL, 2'b00};
    localparam logic [11:0] PHSR_ADDR_STATUS    = {PHSR_IDX_STATUS, 2'b00};

    // Holdover control field positions
    localparam int          PHSR_CTRL_HOLD_EN   = 0;
    localparam int          PHSR_CTRL_EXT_HOLD  = 1;
    localparam int          PHSR_CTRL_HOLD_EN2  = 2;
    localparam int          PHSR_CTRL_LD_CMP    = 3;
    localparam int          PHSR_CTRL_STAT_DIS  = 4;
    localparam logic [4:0]  PHSR_CTRL_MASK      = 5'h1F;
    localparam logic [7:0]  PHSR_CTRL_RST       = 8'h00;

    // Status field positions
    localparam int          PHSR_ST_LOCK        = 0;
    localparam int          PHSR_ST_REFA_THR    = 1;
    localparam int          PHSR_ST_REFB_THR    = 2;
    localparam int          PHSR_ST_OSC_THR     = 3;
    localparam int          PHSR_ST_REFB_SEL    = 4;
    localparam int          PHSR_ST_HOLD_ACT    = 5;
    localparam int          PHSR_ST_CAL_DONE    = 6;
    localparam int          PHSR_ST_ALIGN_PIN   = 7;
    localparam int          PHSR_SYNC_W         = 8;

    // AXI responses
    localparam logic [1:0]  PHSR_RESP_OKAY      = 2'h0;
    localparam logic [1:0]  PHSR_RESP_SLVERR    = 2'h2;

    localparam logic [31:0] PHSR_ZERO_WORD      = 32'h00000000;

    typedef enum logic [0:0] {
        PHSR_WS_COLLECT = 1'b0,
        PHSR_WS_RESP    = 1'b1
    } phsr_wstate_type;

endpackage

// ==== verilog/phsr_sync.sv ====
// Multi-bit two-flop synchroniser, one chain per bit
`timescale 1ns/10ps
module phsr_sync #(
    parameter int WIDTH  = 8,
    parameter int STAGES = 2
) (
    input  wire logic             i_mclk,
    input  wire logic             i_reset_n,
    input  wire logic [WIDTH-1:0] i_async,
    output logic      [WIDTH-1:0] o_sync
);

    generate
        if (STAGES < 2 || WIDTH < 1) begin : g_bad_cfg
            $error("phsr_sync needs at least two stages and one bit");
        end
    endgenerate

    genvar b;
    generate
        for (b = 0; b < WIDTH; b = b + 1) begin : g_bit
            logic [STAGES-1:0] chain_q;
            // Only the last stage is ever read outside the chain
            always_ff @(posedge i_mclk) begin
                if (!i_reset_n) begin
                    chain_q <= '0;
                end else begin
                    chain_q <= {chain_q[STAGES-2:0], i_async[b]};
                end
            end
            assign o_sync[b] = chain_q[STAGES-1];
        end
    endgenerate

endmodule // phsr_sync

// ==== verilog/phsr_regs.sv ====
// Holdover control and synthesizer status registers behind an AXI4-Lite slave
`timescale 1ns/10ps
module phsr_regs #(
    parameter int SYNC_STAGES = phsr_pkg::PHSR_SYNC_STAGES
) (
    input  wire logic                             I_MCLK,
    input  wire logic                             I_RESET_N,
    input  wire logic [phsr_pkg::PHSR_ADDR_W-1:0] I_AWADDR,
    input  wire logic                             I_AWVALID,
    output logic                                  O_AWREADY,
    input  wire logic [phsr_pkg::PHSR_DATA_W-1:0] I_WDATA,
    input  wire logic [3:0]                       I_WSTRB,
    input  wire logic                             I_WVALID,
    output logic                                  O_WREADY,
    output logic [1:0]                            O_BRESP,
    output logic                                  O_BVALID,
    input  wire logic                             I_BREADY,
    input  wire logic [phsr_pkg::PHSR_ADDR_W-1:0] I_ARADDR,
    input  wire logic                             I_ARVALID,
    output logic                                  O_ARREADY,
    output logic [phsr_pkg::PHSR_DATA_W-1:0]      O_RDATA,
    output logic [1:0]                            O_RRESP,
    output logic                                  O_RVALID,
    input  wire logic                             I_RREADY,
    input  wire logic                             I_CAL_DONE,
    input  wire logic                             I_HOLD_ACTIVE,
    input  wire logic                             I_REF_B_SELECTED,
    input  wire logic                             I_OSC_ABOVE_THR,
    input  wire logic                             I_REF_B_ABOVE_THR,
    input  wire logic                             I_REF_A_ABOVE_THR,
    input  wire logic                             I_PLL_LOCKED,
    input  wire logic                             I_ALIGN_PIN,
    input  wire logic                             I_AUTO_HOLD_REQ,
    output logic                                  O_HOLDOVER_EN,
    output logic                                  O_AUTO_HOLD_EN,
    output logic                                  O_HOLD_ENTER,
    output logic                                  O_LD_CMP_EN
);
    import phsr_pkg::*;

    generate
        if (SYNC_STAGES < 2) begin : g_bad_cfg
            $error("phsr_regs needs at least two synchroniser stages");
        end
    endgenerate

    logic [PHSR_SYNC_W-1:0] async_in;
    logic [PHSR_SYNC_W-1:0] sync_out;
    logic [PHSR_REG_W-1:0]  status_v;
    logic                   align_s;

    logic [PHSR_REG_W-1:0]  ctrl_q;
    phsr_wstate_type        wstate_q;
    logic                   aw_got_q;
    logic                   w_got_q;
    logic [PHSR_ADDR_W-1:0] aw_addr_q;
    logic [PHSR_REG_W-1:0]  w_data_q;
    logic                   w_strb_q;
    logic [1:0]             bresp_q;
    logic                   rvalid_q;
    logic [PHSR_DATA_W-1:0] rdata_q;
    logic [1:0]             rresp_q;
    logic                   hold_enter_q;
    logic                   wr_fire;
    logic                   ar_fire;

    // Status sources come from other analog domains, so all are synchronised
    assign async_in = {I_ALIGN_PIN, I_CAL_DONE, I_HOLD_ACTIVE, I_REF_B_SELECTED,
                       I_OSC_ABOVE_THR, I_REF_B_ABOVE_THR, I_REF_A_ABOVE_THR,
                       I_PLL_LOCKED};

    phsr_sync #(
        .WIDTH  (PHSR_SYNC_W),
        .STAGES (SYNC_STAGES)
    ) u_sync (
        .i_mclk    (I_MCLK),
        .i_reset_n (I_RESET_N),
        .i_async   (async_in),
        .o_sync    (sync_out)
    );

    assign align_s = sync_out[PHSR_ST_ALIGN_PIN];

    assign status_v = {1'b0, sync_out[PHSR_ST_CAL_DONE:PHSR_ST_LOCK]};

    // Write channel handshakes
    assign O_AWREADY = !aw_got_q && (wstate_q == PHSR_WS_COLLECT);
    assign O_WREADY  = !w_got_q && (wstate_q == PHSR_WS_COLLECT);
    assign O_BVALID  = (wstate_q == PHSR_WS_RESP);
    assign O_BRESP   = bresp_q;
    assign wr_fire   = (wstate_q == PHSR_WS_COLLECT) && aw_got_q && w_got_q;

    always_ff @(posedge I_MCLK) begin
        if (!I_RESET_N) begin
            aw_got_q  <= 1'b0;
            aw_addr_q <= '0;
        end else if (O_AWREADY && I_AWVALID) begin
            aw_got_q  <= 1'b1;
            aw_addr_q <= I_AWADDR;
        end else if (wr_fire) begin
            aw_got_q  <= 1'b0;
        end
    end

    always_ff @(posedge I_MCLK) begin
        if (!I_RESET_N) begin
            w_got_q  <= 1'b0;
            w_data_q <= '0;
            w_strb_q <= 1'b0;
        end else if (O_WREADY && I_WVALID) begin
            w_got_q  <= 1'b1;
            w_data_q <= I_WDATA[PHSR_REG_W-1:0];
            w_strb_q <= I_WSTRB[0];
        end else if (wr_fire) begin
            w_got_q  <= 1'b0;
        end
    end

    always_ff @(posedge I_MCLK) begin
        if (!I_RESET_N) begin
            wstate_q <= PHSR_WS_COLLECT;
            bresp_q  <= PHSR_RESP_OKAY;
        end else begin
            case (wstate_q)
                PHSR_WS_COLLECT: begin
                    if (wr_fire) begin
                        wstate_q <= PHSR_WS_RESP;
                        if (aw_addr_q == PHSR_ADDR_HOLD_CTRL ||
                            aw_addr_q == PHSR_ADDR_STATUS) begin
                            bresp_q <= PHSR_RESP_OKAY;
                        end else begin
                            bresp_q <= PHSR_RESP_SLVERR;
                        end
                    end
                end
                PHSR_WS_RESP: begin
                    if (I_BREADY) begin
                        wstate_q <= PHSR_WS_COLLECT;
                    end
                end
                default: begin
                    wstate_q <= PHSR_WS_COLLECT;
                end
            endcase
        end
    end

    // status offset holds no storage, writes fall away
    always_ff @(posedge I_MCLK) begin
        if (!I_RESET_N) begin
            ctrl_q <= PHSR_CTRL_RST;
        end else if (wr_fire && w_strb_q && aw_addr_q == PHSR_ADDR_HOLD_CTRL) begin
            ctrl_q <= {3'h0, w_data_q[4:0] & PHSR_CTRL_MASK};
        end
    end

    // Read channel; one read outstanding, answer one cycle after address
    assign O_ARREADY = !rvalid_q;
    assign O_RVALID  = rvalid_q;
    assign O_RDATA   = rdata_q;
    assign O_RRESP   = rresp_q;
    assign ar_fire   = O_ARREADY && I_ARVALID;

    always_ff @(posedge I_MCLK) begin
        if (!I_RESET_N) begin
            rvalid_q <= 1'b0;
            rdata_q  <= PHSR_ZERO_WORD;
            rresp_q  <= PHSR_RESP_OKAY;
        end else if (ar_fire) begin
            rvalid_q <= 1'b1;
            rresp_q  <= PHSR_RESP_OKAY;
            if (I_ARADDR == PHSR_ADDR_HOLD_CTRL) begin
                rdata_q <= {24'h000000, ctrl_q};
            end else if (I_ARADDR == PHSR_ADDR_STATUS) begin
                if (ctrl_q[PHSR_CTRL_STAT_DIS]) begin
                    rdata_q <= PHSR_ZERO_WORD;
                end else begin
                    rdata_q <= {24'h000000, status_v};
                end
            end else begin
                rdata_q <= PHSR_ZERO_WORD;
                rresp_q <= PHSR_RESP_SLVERR;
            end
        end else if (I_RREADY) begin
            rvalid_q <= 1'b0;
        end
    end

    assign O_HOLDOVER_EN  = ctrl_q[PHSR_CTRL_HOLD_EN] && ctrl_q[PHSR_CTRL_HOLD_EN2];
    // automatic circuit only outside external mode
    assign O_AUTO_HOLD_EN = O_HOLDOVER_EN && !ctrl_q[PHSR_CTRL_EXT_HOLD];
    assign O_LD_CMP_EN    = ctrl_q[PHSR_CTRL_LD_CMP];
    assign O_HOLD_ENTER   = hold_enter_q;

    // pin or auto request selects entry
    always_ff @(posedge I_MCLK) begin
        if (!I_RESET_N) begin
            hold_enter_q <= 1'b0;
        end else if (!O_HOLDOVER_EN) begin
            hold_enter_q <= 1'b0;
        end else if (ctrl_q[PHSR_CTRL_EXT_HOLD]) begin
            hold_enter_q <= align_s;
        end else begin
            hold_enter_q <= I_AUTO_HOLD_REQ;
        end
    end

    // Checks
    default clocking cb @(posedge I_MCLK); endclocking
    default disable iff (!I_RESET_N);

    sequence ctrl_wr_s;
        wr_fire && w_strb_q && aw_addr_q == PHSR_ADDR_HOLD_CTRL;
    endsequence

    sequence stat_rd_s;
        ar_fire && I_ARADDR == PHSR_ADDR_STATUS && !ctrl_q[PHSR_CTRL_STAT_DIS];
    endsequence

    hold_en_both_a: assert property (
        ctrl_wr_s |=> (O_HOLDOVER_EN == ($past(w_data_q[0]) && $past(w_data_q[2]))))
        else $error("holdover enable does not follow both bits");

    hold_en_reset_a: assert property (
        $past(!I_RESET_N) |-> (ctrl_q == PHSR_CTRL_RST) && !O_HOLDOVER_EN)
        else $error("holdover enabled after reset");

    ext_pin_hold_a: assert property (
        O_HOLDOVER_EN && ctrl_q[PHSR_CTRL_EXT_HOLD] |=> (O_HOLD_ENTER == $past(align_s)))
        else $error("external holdover not taken from pin");

    auto_hold_a: assert property (
        O_HOLDOVER_EN && !ctrl_q[PHSR_CTRL_EXT_HOLD]
            |=> (O_HOLD_ENTER == $past(I_AUTO_HOLD_REQ)))
        else $error("automatic holdover not taken from circuit");

    cal_done_bit_a: assert property (
        stat_rd_s |=> O_RVALID && O_RDATA[6] == $past(sync_out[PHSR_ST_CAL_DONE]))
        else $error("calibration status bit wrong");

    hold_active_bit_a: assert property (
        stat_rd_s ##0 (sync_out[PHSR_ST_HOLD_ACT] != O_HOLDOVER_EN)
            |=> O_RDATA[5] == $past(sync_out[PHSR_ST_HOLD_ACT]))
        else $error("holdover active bit follows enable");

    ref_b_sel_a: assert property (
        stat_rd_s |=> O_RDATA[4] == $past(sync_out[PHSR_ST_REFB_SEL]))
        else $error("reference select bit wrong");

    thr_lock_bits_a: assert property (
        stat_rd_s |=> O_RDATA[3:0] == $past(sync_out[3:0]))
        else $error("threshold or lock bits wrong");

    ref_b_thr_a: assert property (
        $rose(I_REF_B_ABOVE_THR) ##1 I_REF_B_ABOVE_THR[*2] |-> status_v[2])
        else $error("reference B threshold bit late");

    ref_a_thr_a: assert property (
        $fell(I_REF_A_ABOVE_THR) ##1 (!I_REF_A_ABOVE_THR)[*2] |-> !status_v[1])
        else $error("reference A threshold bit late");

    lock_live_a: assert property (
        I_PLL_LOCKED[*3] |-> status_v[0])
        else $error("lock bit not live");

    stat_wr_ignored_a: assert property (
        wr_fire && aw_addr_q == PHSR_ADDR_STATUS |=> $stable(ctrl_q) ##0 O_BVALID)
        else $error("status write changed control");

    stat_disable_a: assert property (
        ar_fire && I_ARADDR == PHSR_ADDR_STATUS && ctrl_q[PHSR_CTRL_STAT_DIS]
            |=> O_RVALID && O_RDATA == PHSR_ZERO_WORD)
        else $error("status read while disabled");

    stat_wr_okay_a: assert property (
        wr_fire && aw_addr_q == PHSR_ADDR_STATUS |=> O_BVALID && O_BRESP == PHSR_RESP_OKAY)
        else $error("status write not acknowledged");

    // Unmapped or strobe-less writes must not leak into control
    ctrl_only_wr_a: assert property (
        !(wr_fire && w_strb_q && aw_addr_q == PHSR_ADDR_HOLD_CTRL) |=> $stable(ctrl_q))
        else $error("control changed without a control write");

endmodule // phsr_regs

// ==== bench/tb_phsr_regs.sv ====
// Self-checking bench for the holdover control and status registers
`timescale 1ns/10ps
module tb_phsr_regs;
    import phsr_pkg::*;
    logic        I_MCLK, I_RESET_N, I_AWVALID, I_WVALID, I_BREADY, I_ARVALID, I_RREADY;
    logic [11:0] I_AWADDR, I_ARADDR;
    logic [31:0] I_WDATA;
    logic [3:0]  I_WSTRB;
    logic [6:0]  src;
    logic        I_ALIGN_PIN, I_AUTO_HOLD_REQ;
    logic        O_AWREADY, O_WREADY, O_BVALID, O_ARREADY, O_RVALID;
    logic [1:0]  O_BRESP, O_RRESP;
    logic [31:0] O_RDATA, x, d;
    logic        O_HOLDOVER_EN, O_AUTO_HOLD_EN, O_HOLD_ENTER, O_LD_CMP_EN, en, he;
    logic [33:0] rq[$];
    logic [33:0] st_e;
    logic [1:0]  bq[$];
    int          err_count, checked, n, k;
    phsr_regs i_dut (.I_MCLK(I_MCLK), .I_RESET_N(I_RESET_N), .I_AWADDR(I_AWADDR),
        .I_AWVALID(I_AWVALID), .O_AWREADY(O_AWREADY), .I_WDATA(I_WDATA), .I_WSTRB(I_WSTRB),
        .I_WVALID(I_WVALID), .O_WREADY(O_WREADY), .O_BRESP(O_BRESP), .O_BVALID(O_BVALID),
        .I_BREADY(I_BREADY), .I_ARADDR(I_ARADDR), .I_ARVALID(I_ARVALID),
        .O_ARREADY(O_ARREADY), .O_RDATA(O_RDATA), .O_RRESP(O_RRESP), .O_RVALID(O_RVALID),
        .I_RREADY(I_RREADY), .I_CAL_DONE(src[6]), .I_HOLD_ACTIVE(src[5]),
        .I_REF_B_SELECTED(src[4]), .I_OSC_ABOVE_THR(src[3]), .I_REF_B_ABOVE_THR(src[2]),
        .I_REF_A_ABOVE_THR(src[1]), .I_PLL_LOCKED(src[0]), .I_ALIGN_PIN(I_ALIGN_PIN),
        .I_AUTO_HOLD_REQ(I_AUTO_HOLD_REQ), .O_HOLDOVER_EN(O_HOLDOVER_EN),
        .O_AUTO_HOLD_EN(O_AUTO_HOLD_EN), .O_HOLD_ENTER(O_HOLD_ENTER),
        .O_LD_CMP_EN(O_LD_CMP_EN));
    initial begin
        I_MCLK = 1'b0;
        forever #5 I_MCLK = ~I_MCLK;
    end
    function automatic logic [31:0] rnd();
        x = x ^ (x << 13);
        x = x ^ (x >> 17);
        x = x ^ (x << 5);
        return x;
    endfunction
    task automatic stop_test();
        $display("Checks %0d, mismatches %0d", checked, err_count);
        if (err_count == 0 && checked > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    task automatic chk(input string nm, input logic [33:0] e, input logic [33:0] s);
        checked++;
        if (e !== s) begin
            $display("CHECK FAILED %s expected %h seen %h", nm, e, s);
            err_count++;
        end
    endtask
    task automatic bound(input int c);
        if (c >= 60) begin
            $display("CHECK FAILED handshake wait expected 1 seen 0");
            err_count++;
            stop_test();
        end
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] v, input logic [1:0] r);
        logic ad, wd, ta, tw;
        bq.push_back(r);
        @(posedge I_MCLK);
        I_AWADDR <= a; I_AWVALID <= 1'b1; I_WDATA <= v; I_WVALID <= 1'b1; I_BREADY <= 1'b1;
        ad = 0; wd = 0;
        for (n = 0; !(ad && wd) && n < 60; n++) begin
            @(negedge I_MCLK);
            ta = !ad && O_AWREADY === 1'b1;
            tw = !wd && O_WREADY === 1'b1;
            @(posedge I_MCLK);
            if (ta) begin I_AWVALID <= 1'b0; ad = 1; end
            if (tw) begin I_WVALID <= 1'b0; wd = 1; end
        end
        bound(n);
        @(negedge I_MCLK);
        for (n = 0; O_BVALID !== 1'b1 && n < 60; n++) @(negedge I_MCLK);
        bound(n);
        @(posedge I_MCLK);
        I_BREADY <= 1'b0;
    endtask
    task automatic rd(input logic [11:0] a, input logic [33:0] e);
        rq.push_back(e);
        @(posedge I_MCLK);
        I_ARADDR <= a; I_ARVALID <= 1'b1; I_RREADY <= 1'b1;
        @(negedge I_MCLK);
        for (n = 0; O_ARREADY !== 1'b1 && n < 60; n++) @(negedge I_MCLK);
        bound(n);
        @(posedge I_MCLK);
        I_ARVALID <= 1'b0;
        @(negedge I_MCLK);
        for (n = 0; O_RVALID !== 1'b1 && n < 60; n++) @(negedge I_MCLK);
        bound(n);
        @(posedge I_MCLK);
        I_RREADY <= 1'b0;
    endtask
    // Response monitor, sampled mid-cycle where handshake values are settled
    always @(negedge I_MCLK) begin
        if (O_RVALID === 1'b1 && I_RREADY === 1'b1) begin
            if (rq.size() == 0) chk("unexpected read", 34'h0, 34'h1);
            else chk("read response", rq.pop_front(), {O_RRESP, O_RDATA});
        end
        if (O_BVALID === 1'b1 && I_BREADY === 1'b1) begin
            if (bq.size() == 0) chk("unexpected write", 34'h0, 34'h1);
            else chk("write response", {32'h0, bq.pop_front()}, {32'h0, O_BRESP});
        end
    end
    initial begin
        x = 32'hB81307BB; err_count = 0; checked = 0; src = 7'h00;
        I_RESET_N = 1'b0; I_AWVALID = 1'b0; I_WVALID = 1'b0; I_BREADY = 1'b0;
        I_ARVALID = 1'b0; I_RREADY = 1'b0; I_AWADDR = 12'h000; I_ARADDR = 12'h000;
        I_WDATA = 32'h0; I_WSTRB = 4'hF; I_ALIGN_PIN = 1'b0; I_AUTO_HOLD_REQ = 1'b0;
        repeat (12) @(posedge I_MCLK);
        I_RESET_N <= 1'b1;
        rd(PHSR_ADDR_HOLD_CTRL, {PHSR_RESP_OKAY, 32'h0});
        for (k = 0; k < 16; k++) begin
            // Enables walk all eight codes, status disable clear, comparator bit and bits 5 up random
            d = (rnd() & 32'hFFFFFFE8) | 32'(k & 7);
            wr(PHSR_ADDR_HOLD_CTRL, d, PHSR_RESP_OKAY);
            rd(PHSR_ADDR_HOLD_CTRL, {PHSR_RESP_OKAY, 27'h0, d[4:0]});
            @(posedge I_MCLK);
            I_ALIGN_PIN <= x[7]; I_AUTO_HOLD_REQ <= x[9];
            repeat (6) @(posedge I_MCLK);
            @(negedge I_MCLK);
            en = d[0] & d[2];
            chk("holdover enable", {33'h0, en}, {33'h0, O_HOLDOVER_EN});
            chk("auto enable", {33'h0, en & !d[1]}, {33'h0, O_AUTO_HOLD_EN});
            he = en & (d[1] ? x[7] : x[9]);
            chk("hold enter", {33'h0, he}, {33'h0, O_HOLD_ENTER});
            chk("lock comparator", {33'h0, d[3]}, {33'h0, O_LD_CMP_EN});
        end
        // Automatic holdover kept off while all seven status sources vary
        wr(PHSR_ADDR_HOLD_CTRL, 32'h0, PHSR_RESP_OKAY);
        for (k = 0; k < 24; k++) begin
            @(posedge I_MCLK);
            src <= 7'(rnd());
            repeat (4) @(posedge I_MCLK);
            st_e = {PHSR_RESP_OKAY, 25'h0, src};
            rd(PHSR_ADDR_STATUS, st_e);
        end
        // Status writes leave the live view unchanged
        wr(PHSR_ADDR_STATUS, ~{25'h0, src}, PHSR_RESP_OKAY);
        rd(PHSR_ADDR_STATUS, {PHSR_RESP_OKAY, 25'h0, src});
        wr(PHSR_ADDR_HOLD_CTRL, 32'h10, PHSR_RESP_OKAY);
        rd(PHSR_ADDR_STATUS, {PHSR_RESP_OKAY, 32'h0});
        wr(PHSR_ADDR_HOLD_CTRL, 32'h0, PHSR_RESP_OKAY);
        rd(PHSR_ADDR_STATUS, {PHSR_RESP_OKAY, 25'h0, src});
        // Unmapped place answers with an error and stores nothing
        wr(12'h100, 32'hFF, PHSR_RESP_SLVERR);
        rd(12'h100, {PHSR_RESP_SLVERR, 32'h0});
        rd(PHSR_ADDR_HOLD_CTRL, {PHSR_RESP_OKAY, 32'h0});
        // Low byte strobe clear: answered but nothing stored
        I_WSTRB <= 4'hE;
        wr(PHSR_ADDR_HOLD_CTRL, 32'h1F, PHSR_RESP_OKAY);
        I_WSTRB <= 4'hF;
        rd(PHSR_ADDR_HOLD_CTRL, {PHSR_RESP_OKAY, 32'h0});
        repeat (4) @(posedge I_MCLK);
        chk("queues empty", 34'h0, 34'(rq.size() + bq.size()));
        stop_test();
    end
endmodule // tb_phsr_regs
